// >>> logic/crs_pkg.sv
// package for the cpu core state and reset block
package crs_pkg;
  // condition flag bit positions
  localparam int unsigned FLAG_HALF_POS  = 4;
  localparam int unsigned FLAG_MASK_POS  = 3;
  localparam int unsigned FLAG_NEG_POS   = 2;
  localparam int unsigned FLAG_ZERO_POS  = 1;
  localparam int unsigned FLAG_CARRY_POS = 0;
  // fixed upper flag bits and reset value of the flag register
  localparam logic [2:0]  FLAG_FIXED_ONES = 3'h7;
  localparam logic [7:0]  FLAG_RESET_VAL  = 8'he8;
  // stack pointer layout
  localparam logic [15:0] STACK_RESET_VAL = 16'h017f;
  localparam logic [8:0]  STACK_FIXED_HI  = 9'h002;
  localparam logic [6:0]  STACK_TOP_FIELD = 7'h7f;
  localparam int unsigned STACK_FIELD_W   = 7;
  // stack bytes per context
  localparam logic [2:0]  CALL_FRAME_BYTES = 3'h2;
  localparam logic [2:0]  IRQ_FRAME_BYTES  = 3'h5;
  // reset vector address
  localparam logic [15:0] RESET_VEC_LO_ADDR = 16'hfffe;
  localparam logic [15:0] RESET_VEC_HI_ADDR = 16'hffff;
  // start-up delay in cpu clock cycles
  localparam int unsigned STARTUP_CYCLES = 4096;
  localparam int unsigned STARTUP_CNT_W  = 13;
  // state operations requested by the sequencer
  typedef enum logic [3:0] {
    CRS_OP_NONE,
    CRS_OP_ALU,        // load result to accumulator if alu_to_acc_i, update n z (h c optional)
    CRS_OP_LOAD_X,
    CRS_OP_LOAD_Y,
    CRS_OP_LOAD_SPL,   // ordinary load into stack pointer low byte
    CRS_OP_PUSH,       // push op_data_i
    CRS_OP_POP,        // pop one byte
    CRS_OP_IRQ_ENTRY,  // push five-byte context then mask
    CRS_OP_IRQ_RETURN, // pop five-byte context
    CRS_OP_SP_RESTORE,
    CRS_OP_MASK_SET,
    CRS_OP_MASK_CLEAR,
    CRS_OP_CARRY_SET,
    CRS_OP_CARRY_CLEAR,
    CRS_OP_JUMP
  } crs_op_t;
endpackage

// >>> logic/crs_stack_ptr.sv
// stack pointer with seven writable bits and silent wrap
`timescale 1ns/1ps
`default_nettype none
module crs_stack_ptr
  import crs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        srst_i,     // internal reset, held until vector fetch
  input  wire logic        dec_i,      // after each pushed byte
  input  wire logic        inc_i,      // before each popped byte
  input  wire logic        restore_i,  // restore op
  input  wire logic        load_i,     // ordinary load of low byte
  input  wire logic [7:0]  load_data_i,
  output logic      [15:0] sp_o,       // next free location
  output logic      [15:0] sp_pre_inc_o // address read by a pop
);
  logic [6:0] field_q; // only writable part
  logic [6:0] field_d;

  // next value of the writable field
  always_comb begin
    field_d = field_q;
    if (restore_i) begin
      field_d = STACK_TOP_FIELD; // RQ14
    end else if (load_i) begin
      field_d = load_data_i[6:0]; // RQ17
    end else if (dec_i) begin
      field_d = field_q - 7'h01; // RQ13 RQ15
    end else if (inc_i) begin
      field_d = field_q + 7'h01; // RQ13 RQ15
    end
  end

  // register the field
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      field_q <= STACK_TOP_FIELD; // RQ12
    end else begin
      field_q <= field_d;
    end
  end

  // upper nine bits forced by hardware
  assign sp_o         = {STACK_FIXED_HI, field_q}; // RQ12
  assign sp_pre_inc_o = {STACK_FIXED_HI, 7'(field_q + 7'h01)};
endmodule
`default_nettype wire

// >>> logic/crs_reset_ctrl.sv
// reset source merge, pin driver and start-up counter
`timescale 1ns/1ps
`default_nettype none
module crs_reset_ctrl
  import crs_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic osc_active_i,     // oscillator running, asynchronous
  input  wire logic low_supply_rst_i, // from low_supply_detector, asynchronous
  input  wire logic watchdog_rst_i,   // same clock
  input  wire logic reset_pin_n_i,    // sensed level of the reset pin
  output logic      reset_pin_n_o,    // always low when driven
  output logic      reset_pin_oe_o,   // high while pulling the pin low
  output logic      core_rst_o        // internal reset of the core
);
  logic [1:0] osc_sync_q;
  logic [1:0] lsd_sync_q;
  logic [1:0] pin_sync_q;
  logic [STARTUP_CNT_W-1:0] cnt_q;
  logic [STARTUP_CNT_W-1:0] cnt_d;
  logic any_src;

  // two-flop synchronisers for off-domain inputs
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      osc_sync_q <= 2'h0;
      lsd_sync_q <= 2'h3;
      pin_sync_q <= 2'h0;
    end else begin
      osc_sync_q <= {osc_sync_q[0], osc_active_i};
      lsd_sync_q <= {lsd_sync_q[0], low_supply_rst_i};
      pin_sync_q <= {pin_sync_q[0], reset_pin_n_i};
    end
  end

  // any of three sources restarts the procedure
  assign any_src = lsd_sync_q[1] | watchdog_rst_i | ~pin_sync_q[1]; // RQ20

  // start-up counter, counted only while oscillator active and sources released
  always_comb begin
    cnt_d = cnt_q;
    if (any_src || !osc_sync_q[1]) begin
      cnt_d = '0; // RQ24
    end else if (cnt_q != STARTUP_CNT_W'(STARTUP_CYCLES)) begin
      cnt_d = cnt_q + 1'b1; // RQ19
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // pin pulled low by supply and watchdog resets only; the pin itself
  // is filtered by the sync, so pulses under 1.5 cycles may be missed RQ22
  assign reset_pin_n_o  = 1'b0;
  assign reset_pin_oe_o = lsd_sync_q[1] | watchdog_rst_i; // RQ21
  assign core_rst_o     = srst_i | (cnt_q != STARTUP_CNT_W'(STARTUP_CYCLES)); // RQ24
endmodule
`default_nettype wire

// >>> logic/crs_core_state.sv
// architectural state of the 8-bit core with reset sequencing
// Behaviour
// [RQ1] 8-bit accumulator holds operands and results
// [RQ2] second index never saved on interrupts
// [RQ3] 16-bit program counter of two bytes
// [RQ4] flags 8 bits, top three read one
// [RQ5] half carry from bit 3 on adds
// [RQ6] mask set on entry, cleared by software
// [RQ7] masked requests stay pending until unmask
// [RQ8] unmask in handler services pending at once
// [RQ9] negative copies result bit seven
// [RQ10] zero set when result is zero
// [RQ11] carry from arithmetic, set, clear, shifts
// [RQ12] 16-bit stack pointer, seven writable bits
// [RQ13] decrement after push, increment before pop
// [RQ14] restore op reloads stack top value
// [RQ15] stack wraps silently both ways
// [RQ16] call two bytes, interrupt five, low first
// [RQ17] stack low byte loadable by load
// [RQ18] fetch reset vector from top addresses
// [RQ19] wait 4096 cycles after oscillator starts
// [RQ20] supply, watchdog, pin all start reset
// [RQ21] drive pin low on supply/watchdog reset
// [RQ22] external pulse low at least 1.5 cycles
// [RQ23] entry pushes pc, x, a, flags; return restores
// [RQ24] core held until sources free, count done
`timescale 1ns/1ps
`default_nettype none
module crs_core_state
  import crs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        osc_active_i,
  input  wire logic        low_supply_rst_i,
  input  wire logic        watchdog_rst_i,
  input  wire logic        reset_pin_n_i,
  output logic             reset_pin_n_o,
  output logic             reset_pin_oe_o,
  // operation from the sequencer
  input  wire crs_op_t     op_i,
  input  wire logic        op_valid_i,
  input  wire logic [7:0]  op_data_i,     // result, load value or push byte
  input  wire logic        alu_add_i,     // add or add-with-carry: update half carry
  input  wire logic        alu_half_i,    // carry out of bit 3
  input  wire logic        alu_carry_en_i,// op affects carry
  input  wire logic        alu_carry_i,
  input  wire logic        alu_to_acc_i,  // result written to accumulator
  input  wire logic [15:0] jump_addr_i,
  input  wire logic        flags_write_i, // pop into flags register
  // pending interrupt request and trap
  input  wire logic        irq_req_i,     // level from the interrupt controller
  input  wire logic        trap_i,
  // memory port for stack and vector
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic      [15:0] mem_addr_o,
  output logic      [7:0]  mem_wdata_o,
  input  wire logic [7:0]  mem_rdata_i,   // valid the cycle after mem_req_o
  // state outputs
  output logic      [7:0]  acc_o,
  output logic      [7:0]  x_o,
  output logic      [7:0]  y_o,
  output logic      [15:0] pc_o,
  output logic      [7:0]  flags_o,
  output logic      [15:0] sp_o,
  output logic             irq_take_o,    // service a pending request now
  output logic             busy_o,        // sequence in progress or reset
  output logic             core_rst_o
);
  typedef enum logic [2:0] {
    ST_RESET, ST_VEC_LO, ST_VEC_HI, ST_RUN, ST_PUSH_CTX, ST_POP_CTX, ST_POP_WAIT
  } crs_state_t;

  crs_state_t  state_q, state_d;
  logic [7:0]  acc_q, acc_d;
  logic [7:0]  x_q, x_d;
  logic [7:0]  y_q, y_d;
  logic [15:0] pc_q, pc_d;
  logic [4:0]  flg_q, flg_d;     // h i n z c
  logic [2:0]  ctr_q, ctr_d;     // context byte index
  logic [7:0]  byte_q, byte_d;   // captured low vector byte
  logic        sp_dec, sp_inc, sp_restore, sp_load;
  logic [15:0] sp_pre_inc;
  logic        core_rst;
  logic [7:0]  ctx_byte;

  // reset sources and start-up delay
  crs_reset_ctrl u_rst (
    .clk_i            (clk_i),
    .srst_i           (srst_i),
    .osc_active_i     (osc_active_i),
    .low_supply_rst_i (low_supply_rst_i),
    .watchdog_rst_i   (watchdog_rst_i),
    .reset_pin_n_i    (reset_pin_n_i),
    .reset_pin_n_o    (reset_pin_n_o),
    .reset_pin_oe_o   (reset_pin_oe_o),
    .core_rst_o       (core_rst)
  );

  // stack pointer
  crs_stack_ptr u_sp (
    .clk_i        (clk_i),
    .srst_i       (core_rst),
    .dec_i        (sp_dec),
    .inc_i        (sp_inc),
    .restore_i    (sp_restore),
    .load_i       (sp_load),
    .load_data_i  (op_data_i),
    .sp_o         (sp_o),
    .sp_pre_inc_o (sp_pre_inc)
  );

  // context order on the stack: pcl, pch, x, a, flags
  function automatic logic [7:0] ctx_sel(input logic [2:0] idx, input logic [15:0] pc,
                                         input logic [7:0] x, input logic [7:0] a,
                                         input logic [7:0] f);
    case (idx)
      3'h0:    ctx_sel = pc[7:0]; // RQ16
      3'h1:    ctx_sel = pc[15:8];
      3'h2:    ctx_sel = x;
      3'h3:    ctx_sel = a;
      default: ctx_sel = f;
    endcase
  endfunction

  assign flags_o  = {FLAG_FIXED_ONES, flg_q}; // RQ4
  // byte offered to the stack during entry
  assign ctx_byte = ctx_sel(ctr_q, pc_q, x_q, acc_q, flags_o);

  // next state and datapath
  always_comb begin
    state_d    = state_q;
    acc_d      = acc_q;
    x_d        = x_q;
    y_d        = y_q;
    pc_d       = pc_q;
    flg_d      = flg_q;
    ctr_d      = ctr_q;
    byte_d     = byte_q;
    sp_dec     = 1'b0;
    sp_inc     = 1'b0;
    sp_restore = 1'b0;
    sp_load    = 1'b0;
    mem_req_o  = 1'b0;
    mem_we_o   = 1'b0;
    mem_addr_o = sp_o;
    mem_wdata_o = ctx_byte;
    case (state_q)
      ST_RESET: begin
        // held here by core reset, leave for vector fetch
        mem_req_o  = 1'b1;
        mem_addr_o = RESET_VEC_LO_ADDR; // RQ18
        state_d    = ST_VEC_LO;
      end

      ST_VEC_LO: begin
        mem_req_o  = 1'b1;
        mem_addr_o = RESET_VEC_HI_ADDR;
        byte_d     = mem_rdata_i;
        state_d    = ST_VEC_HI;
      end

      ST_VEC_HI: begin
        // vector is high byte at top address
        pc_d    = {mem_rdata_i, byte_q}; // RQ18 RQ3
        state_d = ST_RUN;
      end

      ST_RUN: begin
        if (op_valid_i) begin
          case (op_i)
            CRS_OP_ALU: begin
              if (alu_to_acc_i) begin
                acc_d = op_data_i; // RQ1
              end
              flg_d[FLAG_NEG_POS]  = op_data_i[7]; // RQ9
              flg_d[FLAG_ZERO_POS] = (op_data_i == 8'h00); // RQ10
              if (alu_add_i) begin
                flg_d[FLAG_HALF_POS] = alu_half_i; // RQ5
              end
              if (alu_carry_en_i) begin
                flg_d[FLAG_CARRY_POS] = alu_carry_i; // RQ11
              end
            end

            // plain register loads
            CRS_OP_LOAD_X:      x_d = op_data_i;
            CRS_OP_LOAD_Y:      y_d = op_data_i;
            CRS_OP_LOAD_SPL:    sp_load = 1'b1; // RQ17
            CRS_OP_SP_RESTORE:  sp_restore = 1'b1; // RQ14

            CRS_OP_MASK_SET:    flg_d[FLAG_MASK_POS] = 1'b1; // RQ6
            CRS_OP_MASK_CLEAR:  flg_d[FLAG_MASK_POS] = 1'b0; // RQ6 RQ8
            CRS_OP_CARRY_SET:   flg_d[FLAG_CARRY_POS] = 1'b1; // RQ11
            CRS_OP_CARRY_CLEAR: flg_d[FLAG_CARRY_POS] = 1'b0; // RQ11

            CRS_OP_JUMP:        pc_d = jump_addr_i;

            CRS_OP_PUSH: begin
              // write then decrement
              mem_req_o   = 1'b1;
              mem_we_o    = 1'b1;
              mem_wdata_o = op_data_i;
              sp_dec      = 1'b1; // RQ13
            end

            CRS_OP_POP: begin
              // increment then read, byte lands on mem_rdata_i next cycle
              mem_req_o  = 1'b1;
              mem_addr_o = sp_pre_inc;
              sp_inc     = 1'b1; // RQ13
            end

            CRS_OP_IRQ_ENTRY: begin
              ctr_d   = 3'h0;
              state_d = ST_PUSH_CTX; // RQ23
            end

            CRS_OP_IRQ_RETURN: begin
              ctr_d   = IRQ_FRAME_BYTES - 3'h1;
              state_d = ST_POP_CTX; // RQ23
            end
            default: begin
              pc_d = pc_q;
            end
          endcase

          if (flags_write_i) begin
            flg_d = op_data_i[4:0];
          end
        end
      end

      ST_PUSH_CTX: begin
        // five bytes, low pc first at current sp; y is not part of it
        mem_req_o = 1'b1;
        mem_we_o  = 1'b1;
        sp_dec    = 1'b1; // RQ16 RQ2
        ctr_d     = ctr_q + 3'h1;
        if (ctr_q == IRQ_FRAME_BYTES - 3'h1) begin
          flg_d[FLAG_MASK_POS] = 1'b1; // RQ6 RQ23
          state_d = ST_RUN;
        end
      end

      ST_POP_CTX: begin
        // pop in reverse: flags, a, x, pch, pcl
        mem_req_o  = 1'b1;
        mem_addr_o = sp_pre_inc;
        sp_inc     = 1'b1;
        state_d    = ST_POP_WAIT;
      end

      ST_POP_WAIT: begin
        case (ctr_q)
          3'h4:    flg_d = mem_rdata_i[4:0]; // RQ23 RQ6
          3'h3:    acc_d = mem_rdata_i;
          3'h2:    x_d = mem_rdata_i;
          3'h1:    pc_d[15:8] = mem_rdata_i;
          default: pc_d[7:0] = mem_rdata_i;
        endcase
        ctr_d   = ctr_q - 3'h1;
        state_d = (ctr_q == 3'h0) ? ST_RUN : ST_POP_CTX;
      end

      default: state_d = ST_RESET;
    endcase
  end

  // register all state; flags undefined at reset taken as zero except mask
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      state_q <= ST_RESET; // RQ24
      acc_q   <= 8'h00;
      x_q     <= 8'h00;
      y_q     <= 8'h00;
      pc_q    <= 16'h0000;
      flg_q   <= FLAG_RESET_VAL[4:0]; // RQ4
      ctr_q   <= 3'h0;
      byte_q  <= 8'h00;

    end else begin
      state_q <= state_d;
      acc_q   <= acc_d;
      x_q     <= x_d;
      y_q     <= y_d;
      pc_q    <= pc_d;
      flg_q   <= flg_d;
      ctr_q   <= ctr_d;
      byte_q  <= byte_d;
    end
  end

  // requests wait while masked; trap ignores the mask
  assign irq_take_o = (state_q == ST_RUN) & (trap_i | (irq_req_i & ~flg_q[FLAG_MASK_POS])); // RQ7 RQ8 RQ6

  // busy also covers the vector fetch after reset
  assign busy_o     = (state_q != ST_RUN);
  assign acc_o      = acc_q;
  assign x_o        = x_q;
  assign y_o        = y_q;
  assign pc_o       = pc_q;
  assign core_rst_o = core_rst;
endmodule
`default_nettype wire

// >>> testbench/crs_core_state_monitor.sv
// assertion checker for the core state and reset block
`timescale 1ns/1ps
`default_nettype none
module crs_core_state_monitor
  import crs_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        srst_i,
  input wire logic        osc_active_i,
  input wire logic        low_supply_rst_i,
  input wire logic        watchdog_rst_i,
  input wire logic        reset_pin_n_o,
  input wire logic        reset_pin_oe_o,
  input wire crs_op_t     op_i,
  input wire logic        op_valid_i,
  input wire logic [7:0]  op_data_i,
  input wire logic        irq_req_i,
  input wire logic        trap_i,
  input wire logic        mem_req_o,
  input wire logic        mem_we_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic [7:0]  mem_wdata_o,
  input wire logic [7:0]  flags_o,
  input wire logic [15:0] sp_o,
  input wire logic        irq_take_o,
  input wire logic        busy_o,
  input wire logic        core_rst_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic [12:0] osc_cnt_q; // running oscillator cycles since reset, saturating
  wire         taken = op_valid_i && !busy_o; // operation accepted this cycle
  // count oscillator cycles; saturation keeps later resets legal
  always_ff @(posedge clk_i) begin
    if (srst_i) osc_cnt_q <= '0;
    else if (osc_active_i && osc_cnt_q != 13'h1fff) osc_cnt_q <= osc_cnt_q + 13'h1;
  end
  // two reads of the top addresses in a row
  sequence vec_fetch;
    mem_req_o && !mem_we_o && mem_addr_o == RESET_VEC_LO_ADDR ##1 mem_req_o && mem_addr_o == RESET_VEC_HI_ADDR;
  endsequence
  // byte written at the free location
  sequence push_wr;
    mem_req_o && mem_we_o && mem_addr_o == sp_o && mem_wdata_o == op_data_i;
  endsequence
  fixed_flags_a: assert property (flags_o[7:5] == FLAG_FIXED_ONES)
    else $error("flag top bits not ones");
  fixed_stack_a: assert property (sp_o[15:7] == STACK_FIXED_HI)
    else $error("stack upper bits changed");
  startup_wait_a: assert property ($fell(core_rst_o) |-> osc_cnt_q >= 13'h1000)
    else $error("core released before start-up count");
  vector_fetch_a: assert property ($fell(core_rst_o) |-> ##[0:1] vec_fetch)
    else $error("reset vector not fetched");
  pin_drive_a: assert property (watchdog_rst_i |-> ##[0:3] (reset_pin_oe_o && !reset_pin_n_o))
    else $error("reset pin not pulled low");
  pin_quiet_a: assert property ((!low_supply_rst_i && !watchdog_rst_i)[*5] |-> !reset_pin_oe_o)
    else $error("reset pin driven without source");
  src_reset_a: assert property ((watchdog_rst_i || low_supply_rst_i) |-> ##[0:3] core_rst_o)
    else $error("reset source ignored");
  push_step_a: assert property (taken && op_i == CRS_OP_PUSH |->
    push_wr ##1 sp_o == {STACK_FIXED_HI, $past(sp_o[6:0]) - 7'h01})
    else $error("push write or decrement wrong");
  pop_step_a: assert property (taken && op_i == CRS_OP_POP |=>
    sp_o == {STACK_FIXED_HI, $past(sp_o[6:0]) + 7'h01})
    else $error("pop increment wrong");
  sp_restore_a: assert property (taken && op_i == CRS_OP_SP_RESTORE |=> sp_o == STACK_RESET_VAL)
    else $error("stack restore wrong");
  alu_flags_a: assert property (taken && op_i == CRS_OP_ALU |=> flags_o[FLAG_NEG_POS] == $past(op_data_i[7])
    && flags_o[FLAG_ZERO_POS] == ($past(op_data_i) == 8'h00))
    else $error("negative or zero flag wrong");
  irq_entry_a: assert property (taken && op_i == CRS_OP_IRQ_ENTRY |=>
    (mem_req_o && mem_we_o)[*5] ##[0:1] flags_o[FLAG_MASK_POS])
    else $error("interrupt entry sequence wrong");
  take_gate_a: assert property (irq_take_o |-> trap_i || (irq_req_i && !flags_o[FLAG_MASK_POS]))
    else $error("masked request taken");
endmodule
`default_nettype wire

// >>> testbench/crs_rst_line.sv
// reset line model: pull-up, device pull-down, external requester
`timescale 1ns/1ps
`default_nettype none
module crs_rst_line (
  input  wire logic clk_i,
  input  wire logic push_i,    // start an external reset request
  input  wire logic dut_oe_i,  // device pulls the line
  input  wire logic dut_lvl_i, // level the device drives
  output logic      pin_n_o    // resolved line level
);
  logic [2:0] hold_q = 3'h0; // external low cycles left
  // five cycles low, well above the one and a half minimum
  always @(posedge clk_i) begin
    if (push_i) hold_q <= 3'h5;
    else if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
  end
  // open drain with pull-up: any low driver wins
  assign pin_n_o = !((dut_oe_i && !dut_lvl_i) || hold_q != 3'h0);
endmodule
`default_nettype wire

// >>> testbench/test_crs_core_state.sv
// self-checking bench for the core state and reset block
`timescale 1ns/1ps
`default_nettype none
module test_crs_core_state;
  import crs_pkg::*;
  localparam logic [15:0] VEC = 16'h4a21; // start address held in the vector
  typedef struct {logic [3:0] s; logic [15:0] v;} crs_note_t;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        osc_active_i = 1'b0;
  logic        low_supply_rst_i = 1'b0;
  logic        watchdog_rst_i = 1'b0;
  logic        push = 1'b0;        // external reset request
  crs_op_t     op_i = CRS_OP_NONE;
  logic        op_valid_i = 1'b0;
  logic [7:0]  op_data_i = 8'h00;
  logic [4:0]  alu = 5'h00;        // add, half, carry enable, carry, to accumulator
  logic [15:0] jump_addr_i = 16'h0000;
  logic        irq_req_i = 1'b0;
  logic        trap_i = 1'b0;
  logic [7:0]  mem_rdata_i = 8'h00;
  wire         pin_n;              // resolved reset line
  logic        reset_pin_n_o, reset_pin_oe_o, mem_req_o, mem_we_o, irq_take_o, busy_o, core_rst_o;
  logic [15:0] mem_addr_o, pc_o, sp_o, pcv;
  logic [7:0]  mem_wdata_o, acc_o, x_o, y_o, flags_o, f, a, xv, yv;
  logic [31:0] r = 32'h0f51;       // random state
  logic [7:0]  stk [0:255];        // stack memory
  int          n_errors = 0;
  int          checks = 0;
  int          i;
  crs_note_t   q [$];              // expected state notes
  crs_note_t   cur;
  logic [23:0] wq [$];             // expected stack writes
  event        look;
  crs_core_state DUT (.clk_i, .srst_i, .osc_active_i, .low_supply_rst_i, .watchdog_rst_i, .reset_pin_n_i(pin_n),
    .reset_pin_n_o, .reset_pin_oe_o, .op_i, .op_valid_i, .op_data_i, .alu_add_i(alu[4]), .alu_half_i(alu[3]),
    .alu_carry_en_i(alu[2]), .alu_carry_i(alu[1]), .alu_to_acc_i(alu[0]), .jump_addr_i, .flags_write_i(1'b0),
    .irq_req_i, .trap_i, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_rdata_i, .acc_o, .x_o, .y_o,
    .pc_o, .flags_o, .sp_o, .irq_take_o, .busy_o, .core_rst_o);
  crs_rst_line LINE (.clk_i(clk_i), .push_i(push), .dut_oe_i(reset_pin_oe_o), .dut_lvl_i(reset_pin_n_o),
    .pin_n_o(pin_n));
  always #5 clk_i = ~clk_i;
  // memory answers a cycle after the request
  always @(posedge clk_i) begin
    if (mem_req_o && mem_we_o) stk[mem_addr_o[7:0]] <= mem_wdata_o;
    mem_rdata_i <= mem_addr_o == RESET_VEC_LO_ADDR ? VEC[7:0] :
                   mem_addr_o == RESET_VEC_HI_ADDR ? VEC[15:8] : stk[mem_addr_o[7:0]];
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // observed value for a note selector
  function automatic logic [15:0] pick(input logic [3:0] s);
    case (s)
      4'h0: return 16'(acc_o);
      4'h1: return 16'(x_o);
      4'h2: return 16'(y_o);
      4'h3: return pc_o;
      4'h4: return 16'(flags_o);
      4'h5: return sp_o;
      4'h6: return 16'(irq_take_o);
      4'h7: return 16'(reset_pin_oe_o);
      4'h8: return 16'(core_rst_o);
      default: return 16'(pin_n);
    endcase
  endfunction
  task automatic compare(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic note(input logic [3:0] s, input logic [15:0] v);
    q.push_back('{s, v});
  endtask
  // bounded wait for the run state
  task automatic idle;
    int n;
    n = 0;
    while (busy_o !== 1'b0) begin
      n++;
      if (n > 9000) begin
        n_errors++;
        end_of_test;
      end
      @(negedge clk_i);
    end
  endtask
  // request held for its accepting edge
  task automatic op(input crs_op_t o, input logic [7:0] d, input logic [4:0] u);
    idle;
    @(posedge clk_i);
    op_i <= o;
    op_data_i <= d;
    alu <= u;
    jump_addr_i <= r[31:16];
    op_valid_i <= 1'b1;
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic step(input crs_op_t o, input logic [7:0] d, input logic [3:0] s, input logic [15:0] v);
    op(o, d, 5'h00);
    note(s, v);
    ->look;
  endtask
  // observer: every queued note, oldest first, against the settled outputs
  always @(look) begin
    while (q.size() > 0) begin
      cur = q.pop_front();
      compare({8'h00, pick(cur.s)}, {8'h00, cur.v});
    end
  end
  // observer: each stack write against the oldest expected write
  always @(negedge clk_i) begin
    if (mem_req_o === 1'b1 && mem_we_o === 1'b1) begin
      if (wq.size() == 0) compare({mem_addr_o, mem_wdata_o}, 24'h000000);
      else compare({mem_addr_o, mem_wdata_o}, wq.pop_front());
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    osc_active_i <= 1'b1;
    @(negedge clk_i);
    note(4'h4, {8'h00, FLAG_RESET_VAL});
    note(4'h5, STACK_RESET_VAL);
    ->look;
    for (i = 0; core_rst_o !== 1'b0 && i < 9000; i++) @(negedge clk_i);
    compare(24'(i >= 4096 && i < 4110), 24'h000001);
    idle;
    note(4'h3, VEC);
    ->look;
    // random results; half carry only moves on adds
    f = FLAG_RESET_VAL;
    for (i = 0; i < 6; i++) begin
      r = lfsr(r);
      a = i == 0 ? 8'h00 : r[7:0];
      op(CRS_OP_ALU, a, {r[10], r[8], 1'b1, r[9], 1'b1});
      f = {3'h7, r[10] ? r[8] : f[4], f[3], a[7], a == 8'h00, r[9]};
      note(4'h0, {8'h00, a});
      note(4'h4, {8'h00, f});
      ->look;
    end
    // carry set, carry clear, mask clear, mask set
    for (i = 0; i < 4; i++) begin
      f[i[1] ? 3 : 0] = i[1] ? i[0] : !i[0];
      step(i[1] ? (i[0] ? CRS_OP_MASK_SET : CRS_OP_MASK_CLEAR) : (i[0] ? CRS_OP_CARRY_CLEAR : CRS_OP_CARRY_SET),
           8'h00, 4'h4, {8'h00, f});
    end
    @(posedge clk_i) irq_req_i <= 1'b1;
    @(negedge clk_i);
    note(4'h6, 16'h0000);
    ->look;
    step(CRS_OP_MASK_CLEAR, 8'h00, 4'h6, 16'h0001);
    op(CRS_OP_MASK_SET, 8'h00, 5'h00);
    @(posedge clk_i);
    irq_req_i <= 1'b0;
    trap_i <= 1'b1;
    @(negedge clk_i);
    note(4'h6, 16'h0001);
    ->look;
    @(posedge clk_i) trap_i <= 1'b0;
    op(CRS_OP_MASK_CLEAR, 8'h00, 5'h00);
    f[3] = 1'b0;
    // pushes, pops, low byte load and wrap at both limits
    r = lfsr(r);
    xv = r[7:0];
    yv = r[15:8];
    op(CRS_OP_LOAD_X, xv, 5'h00);
    op(CRS_OP_LOAD_Y, yv, 5'h00);
    wq.push_back({16'h017f, yv});
    step(CRS_OP_PUSH, yv, 4'h5, 16'h017e);
    step(CRS_OP_POP, 8'h00, 4'h5, 16'h017f);
    step(CRS_OP_LOAD_SPL, 8'h80, 4'h5, 16'h0100);
    wq.push_back({16'h0100, xv});
    step(CRS_OP_PUSH, xv, 4'h5, 16'h017f);
    step(CRS_OP_POP, 8'h00, 4'h5, 16'h0100);
    step(CRS_OP_LOAD_SPL, r[23:16], 4'h5, {9'h002, r[22:16]});
    step(CRS_OP_SP_RESTORE, 8'h00, 4'h5, 16'h017f);
    r = lfsr(r);
    pcv = r[31:16];
    step(CRS_OP_JUMP, 8'h00, 4'h3, pcv);
    // context frame: low pc byte first, then down the stack
    wq.push_back({16'h017f, pcv[7:0]});
    wq.push_back({16'h017e, pcv[15:8]});
    wq.push_back({16'h017d, xv});
    wq.push_back({16'h017c, a});
    wq.push_back({16'h017b, f});
    step(CRS_OP_IRQ_ENTRY, 8'h00, 4'h2, {8'h00, yv});
    idle;
    note(4'h5, 16'h017a);
    note(4'h4, {8'h00, f | 8'h08});
    ->look;
    r = lfsr(r);
    op(CRS_OP_LOAD_X, ~xv, 5'h00);
    op(CRS_OP_ALU, ~a, 5'h01);
    op(CRS_OP_JUMP, 8'h00, 5'h00);
    op(CRS_OP_IRQ_RETURN, 8'h00, 5'h00);
    idle;
    note(4'h0, {8'h00, a});
    note(4'h1, {8'h00, xv});
    note(4'h2, {8'h00, yv});
    note(4'h3, pcv);
    note(4'h4, {8'h00, f});
    note(4'h5, 16'h017f);
    ->look;
    // watchdog, external pin, low supply in turn
    for (i = 0; i < 3; i++) begin
      @(posedge clk_i);
      watchdog_rst_i <= i == 0;
      push <= i == 1;
      low_supply_rst_i <= i == 2;
      @(posedge clk_i);
      push <= 1'b0;
      repeat (4) @(negedge clk_i);
      note(4'h8, 16'h0001);
      note(4'h7, {15'h0000, i != 1});
      note(4'h9, 16'h0000);
      ->look;
      @(posedge clk_i);
      watchdog_rst_i <= 1'b0;
      low_supply_rst_i <= 1'b0;
      @(negedge clk_i);
      idle;
      note(4'h3, VEC);
      note(4'h5, STACK_RESET_VAL);
      note(4'h4, {8'h00, FLAG_RESET_VAL});
      ->look;
    end
    end_of_test;
  end
endmodule
bind crs_core_state crs_core_state_monitor MON (.*);
`default_nettype wire
